// ---- cpu_model.sv ----
// behavioural cpu core that answers the interrupt controller
`timescale 1ns/1ps
`default_nettype none

module cpu_model
    import irq_ctl_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bench commands
    input wire logic cli,
    input wire logic brk_cmd,
    // controller side
    input wire irq_ctl_pkg::cpu_out_t cpu_o,
    output irq_ctl_pkg::cpu_in_t cpu_i,
    // observation
    output logic [23:0] push_log,
    output logic [15:0] halt_pc,
    output logic [15:0] last_load,
    output logic [7:0] load_cnt
);
    logic [15:0] pc_r;
    logic iflag_r;
    logic brk_r;
    logic vvld_r;
    logic [7:0] vec_r;

    // ****************************************************************
    // vector rom and live status
    // ****************************************************************
    function automatic logic [7:0] vrom(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    // live break flag is always zero; stale rom data is inverted
    assign cpu_i = '{pc: pc_r, ps: {3'h1, 2'h0, iflag_r, 2'h0}, iflag: iflag_r, software_break_instruction: brk_r,
                     vec_data: vvld_r ? vec_r : ~vec_r};

    // ****************************************************************
    // core state
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pc_r <= 16'h0000;
            iflag_r <= 1'b1;
            brk_r <= 1'b0;
            vvld_r <= 1'b0;
            vec_r <= 8'h00;
            push_log <= 24'h000000;
            halt_pc <= 16'h0000;
            last_load <= 16'h0000;
            load_cnt <= 8'h00;
        end
        else
        begin
            // instruction processing freezes while halted
            if (cpu_o.pc_load)
                pc_r <= cpu_o.pc_value;
            else if (!cpu_o.halt)
                pc_r <= pc_r + 16'h0001;
            if (cpu_o.set_iflag)
                iflag_r <= 1'b1;
            else if (cli)
                iflag_r <= 1'b0;
            brk_r <= brk_cmd & ~cpu_o.halt;
            vvld_r <= cpu_o.vec_rd;
            if (cpu_o.vec_rd)
                vec_r <= vrom(cpu_o.vec_addr);
            if (cpu_o.push)
                push_log <= {push_log[15:0], cpu_o.push_data};
            // pc of the last running cycle, the one in which the grant is taken
            if (!cpu_o.halt)
                halt_pc <= pc_r;
            if (cpu_o.pc_load)
                last_load <= cpu_o.pc_value;
            if (cpu_o.pc_load)
                load_cnt <= load_cnt + 8'h01;
        end
    end

endmodule

`default_nettype wire

// ---- irq_ctl_pkg.sv ----
// constants, register map and carrier types of the interrupt controller
package irq_ctl_pkg;

    // ****************************************************************
    // source counts and layout
    // ****************************************************************
    localparam int NSRC = 23;
    localparam int NEXT = 6;
    localparam int NPER = 17;
    localparam int NALL = 24;
    localparam int IDX_W = 5;
    localparam int EXT_POS [NEXT] = '{1, 2, 9, 15, 16, 22};
    localparam logic [NSRC-1:0] EXT_MASK = 23'h418206;
    localparam logic [NEXT-1:0] POL_RESET = 6'h00;

    // ****************************************************************
    // vectors and status bits
    // ****************************************************************
    localparam logic [15:0] VEC_RESET = 16'hfffa;
    localparam logic [15:0] VEC_FIRST = 16'hfff8;
    localparam logic [15:0] VEC_BRK = 16'hffca;
    localparam int PS_BRK_BIT = 4;

    // ****************************************************************
    // register map (byte offsets)
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_REQ = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_REQ_CLR = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_EN = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_POL = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATE = 8'h10;
    localparam int HTRANS_ACT_BIT = 1;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RLO,
        ST_RHI,
        ST_RFIN,
        ST_PCH,
        ST_PCL,
        ST_PS,
        ST_LOAD
    } accept_state_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] ps;
        logic iflag;
        logic software_break_instruction;
        logic [7:0] vec_data;
    } cpu_in_t;

    typedef struct packed {
        logic irq_req;
        logic halt;
        logic push;
        logic [7:0] push_data;
        logic vec_rd;
        logic [15:0] vec_addr;
        logic pc_load;
        logic [15:0] pc_value;
        logic set_iflag;
    } cpu_out_t;

endpackage

// ---- mcu_interrupt_control.sv ----
// interrupt controller: request latches, enables, priority and acceptance sequence
// Behaviour
// - there are 24 sources: six external edge inputs, seventeen peripheral events and one software break.
// - every source but the break has its own request bit and enable bit and is gated by the global disable flag; the irq output is not gated by it.
// - a maskable source reaches the cpu only while its request and enable are 1 and the disable flag is 0.
// - software can both set and clear each enable bit.
// - software can clear a request bit, writing one never sets it.
// - reset and the break are non-maskable, the disable flag blocks all other sources; the irq output ignores the flag.
// - among simultaneous eligible requests the highest priority is granted first.
// - accepting an interrupt halts the instruction processing in progress.
// - program counter and status are pushed onto the stack automatically.
// - in parallel with the pushes the vector of the granted source is read and loaded into the program counter.
// - acceptance sets the disable flag and clears the request bit of the granted source.
// - changing the active edge of an external source may set its request bit.
// - reset is the top priority vector, each source has a fixed priority and a two-byte vector.
// - polarity bits choose rising or falling edge for each external source.
// - on a break the stacked status carries the break flag as one, the live flag stays zero.
//
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module mcu_interrupt_control
    import irq_ctl_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // event sources
    input wire logic [irq_ctl_pkg::NEXT-1:0] ext_pin,
    input wire logic [irq_ctl_pkg::NSRC-1:0] periph_evt,
    // cpu core
    input wire irq_ctl_pkg::cpu_in_t cpu_i,
    output irq_ctl_pkg::cpu_out_t cpu_o,
    // summary interrupt
    output logic irq
);
    import irq_ctl_pkg::*;

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [NSRC-1:0] req_r;
    logic [NSRC-1:0] req_nxt;
    logic [NSRC-1:0] en_r;
    logic [NEXT-1:0] pol_r;
    logic [NEXT-1:0] ext_prev_r;
    logic [NEXT-1:0] ext_lvl;
    logic [NEXT-1:0] ext_edge;
    logic prime_r;
    logic [NSRC-1:0] evt_all;
    logic [NSRC-1:0] eligible;
    logic [NSRC-1:0] sw_clr;
    logic [NSRC-1:0] acc_clr;
    logic [IDX_W-1:0] gidx;
    logic take_mask;
    logic take_brk;
    logic brk_pend_r;
    logic brk_cur_r;
    logic [IDX_W-1:0] last_idx_r;
    accept_state_t state_r;
    accept_state_t state_nxt;
    logic [15:0] vec_addr_r;
    logic [15:0] pc_save_r;
    logic [7:0] ps_save_r;
    logic [15:0] pc_new_r;
    logic ap_wr_r;
    logic [ADDR_W-1:0] ap_addr_r;
    logic [31:0] hrdata_r;
    logic ap_valid;

    // ****************************************************************
    // external edge detection
    // ****************************************************************
    for (genvar k = 0; k < NEXT; k++)
    begin : g_ext
        assign ext_lvl[k] = ext_pin[k] ^ pol_r[k];
        assign ext_edge[k] = prime_r & ext_lvl[k] & ~ext_prev_r[k];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ext_prev_r <= '0;
            prime_r <= 1'b0;
        end
        else
        begin
            ext_prev_r <= ext_lvl;
            prime_r <= 1'b1;
        end
    end

    always_comb
    begin
        evt_all = periph_evt & ~EXT_MASK;
        for (int k = 0; k < NEXT; k++)
        begin
            evt_all[EXT_POS[k]] = ext_edge[k];
        end
    end

    // ****************************************************************
    // ahb-lite slave
    // ****************************************************************
    assign ap_valid = hsel & htrans[HTRANS_ACT_BIT] & hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_wr_r <= 1'b0;
            ap_addr_r <= '0;
        end
        else
        begin
            ap_wr_r <= ap_valid & hwrite;
            ap_addr_r <= haddr[ADDR_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_r <= '0;
        end
        else if (ap_valid && !hwrite)
        begin
            case (haddr[ADDR_W-1:0])
                OFS_REQ: hrdata_r <= {9'h000, req_r};
                OFS_EN: hrdata_r <= {9'h000, en_r};
                OFS_POL: hrdata_r <= {26'h0000000, pol_r};
                OFS_STATE: hrdata_r <= {23'h000000, state_r != ST_IDLE, cpu_i.iflag,
                                        brk_pend_r, brk_cur_r, last_idx_r};
                default: hrdata_r <= '0;
            endcase
        end
    end

    assign sw_clr = (ap_wr_r && ap_addr_r == OFS_REQ_CLR) ? hwdata[NSRC-1:0] : '0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            en_r <= '0;
        end
        else if (ap_wr_r && ap_addr_r == OFS_EN)
        begin
            en_r <= hwdata[NSRC-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pol_r <= POL_RESET;
        end
        else if (ap_wr_r && ap_addr_r == OFS_POL)
        begin
            pol_r <= hwdata[NEXT-1:0];
        end
    end

    // ****************************************************************
    // request latches and priority
    // ****************************************************************
    assign acc_clr = take_mask ? (NSRC'(1) << gidx) : '0;
    // a new event in the clearing cycle wins
    assign req_nxt = (req_r & ~sw_clr & ~acc_clr) | evt_all;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            req_r <= '0;
        end
        else
        begin
            req_r <= req_nxt;
        end
    end

    assign eligible = cpu_i.iflag ? '0 : (req_r & en_r);
    assign irq = |(req_r & en_r);

    always_comb
    begin
        gidx = '0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (eligible[i])
            begin
                gidx = IDX_W'(i);
            end
        end
    end

    assign take_mask = (state_r == ST_IDLE) && (|eligible);
    assign take_brk = (state_r == ST_IDLE) && brk_pend_r && !take_mask;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            brk_pend_r <= 1'b0;
        end
        else
        begin
            brk_pend_r <= cpu_i.software_break_instruction | (brk_pend_r & ~take_brk);
        end
    end

    // ****************************************************************
    // acceptance sequence
    // ****************************************************************
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (take_mask || take_brk) state_nxt = ST_PCH;
            ST_RLO: state_nxt = ST_RHI;
            ST_RHI: state_nxt = ST_RFIN;
            ST_RFIN: state_nxt = ST_LOAD;
            ST_PCH: state_nxt = ST_PCL;
            ST_PCL: state_nxt = ST_PS;
            ST_PS: state_nxt = ST_LOAD;
            ST_LOAD: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_r <= ST_RLO;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            vec_addr_r <= VEC_RESET;
            pc_save_r <= '0;
            ps_save_r <= '0;
            brk_cur_r <= 1'b0;
            last_idx_r <= '0;
        end
        else if (take_mask || take_brk)
        begin
            vec_addr_r <= take_mask ? 16'(VEC_FIRST - {10'h000, gidx, 1'b0}) : VEC_BRK;
            pc_save_r <= cpu_i.pc;
            ps_save_r <= cpu_i.ps | (take_brk ? (8'h01 << PS_BRK_BIT) : 8'h00);
            brk_cur_r <= take_brk;
            last_idx_r <= take_mask ? gidx : IDX_W'(NSRC);
        end
        else if (state_r == ST_PCH || state_r == ST_RLO)
        begin
            vec_addr_r <= vec_addr_r + 16'h0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pc_new_r <= '0;
        end
        else if (state_r == ST_PCL || state_r == ST_RHI)
        begin
            pc_new_r[7:0] <= cpu_i.vec_data;
        end
        else if (state_r == ST_PS || state_r == ST_RFIN)
        begin
            pc_new_r[15:8] <= cpu_i.vec_data;
        end
    end

    always_comb
    begin
        cpu_o.irq_req = |eligible | brk_pend_r;
        cpu_o.halt = state_r != ST_IDLE;
        cpu_o.push = state_r == ST_PCH || state_r == ST_PCL || state_r == ST_PS;
        case (state_r)
            ST_PCH: cpu_o.push_data = pc_save_r[15:8];
            ST_PCL: cpu_o.push_data = pc_save_r[7:0];
            ST_PS: cpu_o.push_data = ps_save_r;
            default: cpu_o.push_data = '0;
        endcase
        cpu_o.vec_rd = state_r == ST_PCH || state_r == ST_PCL
                       || state_r == ST_RLO || state_r == ST_RHI;
        cpu_o.vec_addr = vec_addr_r;
        cpu_o.pc_load = state_r == ST_LOAD;
        cpu_o.pc_value = pc_new_r;
        cpu_o.set_iflag = state_r == ST_LOAD;
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    AST_RAISE: assert property (@(posedge hclk) disable iff (!hresetn)
        state_r == ST_IDLE && |(req_r & en_r) && !cpu_i.iflag |=> state_r == ST_PCH)
        else $error("eligible request not accepted");

    AST_MASKED: assert property (@(posedge hclk) disable iff (!hresetn)
        state_r == ST_IDLE && cpu_i.iflag && !brk_pend_r |=> state_r == ST_IDLE)
        else $error("source accepted while disable flag set");

    AST_NO_SW_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        ((req_r & ~$past(req_r)) & ~$past(evt_all)) == '0)
        else $error("request bit set without event");

    AST_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        ($past(req_r) & ~req_r & ~$past(sw_clr) & ~$past(acc_clr)) == '0)
        else $error("request bit lost without clear");

    AST_PRIO: assert property (@(posedge hclk) disable iff (!hresetn)
        take_mask |-> (eligible & ((NSRC'(1) << gidx) - NSRC'(1))) == '0 && eligible[gidx])
        else $error("lower priority source granted");

    AST_SEQ: assert property (@(posedge hclk) disable iff (!hresetn)
        state_r == ST_PCH |-> cpu_o.push && cpu_o.halt ##1 cpu_o.push ##1
        (cpu_o.push && cpu_o.push_data == ps_save_r) ##1 (cpu_o.pc_load && !cpu_o.push))
        else $error("stacking sequence broken");

    AST_VEC: assert property (@(posedge hclk) disable iff (!hresetn)
        state_r == ST_PCH |-> cpu_o.vec_rd ##1 (cpu_o.vec_rd
        && cpu_o.vec_addr == $past(cpu_o.vec_addr) + 16'h0001))
        else $error("vector fetch not in step with stacking");

    AST_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
        take_mask && !evt_all[gidx] |=> !req_r[$past(gidx)] ##3 cpu_o.set_iflag)
        else $error("granted request not cleared or flag not set");

    AST_BRK: assert property (@(posedge hclk) disable iff (!hresetn)
        take_brk |=> ##2 cpu_o.push_data[PS_BRK_BIT] && cpu_o.vec_addr == VEC_BRK + 16'h0001)
        else $error("break not stacked with break flag");

    AST_EN: assert property (@(posedge hclk) disable iff (!hresetn)
        ap_wr_r && ap_addr_r == OFS_EN |=> en_r == $past(hwdata[NSRC-1:0]))
        else $error("enable write lost");

    AST_EDGE: assert property (@(posedge hclk) disable iff (!hresetn)
        prime_r && !(ext_pin[0] ^ pol_r[0]) ##1 (ext_pin[0] ^ pol_r[0]) |=> req_r[EXT_POS[0]])
        else $error("selected edge did not set request");

    COV_ACCEPT: cover property (@(posedge hclk) disable iff (!hresetn)
        take_mask ##4 cpu_o.pc_load);
    COV_BRK: cover property (@(posedge hclk) disable iff (!hresetn)
        take_brk ##4 cpu_o.pc_load);
    COV_TWO: cover property (@(posedge hclk) disable iff (!hresetn)
        take_mask && $countones(eligible) > 1);
    COV_SETCLR: cover property (@(posedge hclk) disable iff (!hresetn)
        |(sw_clr & evt_all));

endmodule

`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import irq_ctl_pkg::*;

    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, cli, brk_cmd;
    logic [31:0] haddr, hwdata, hrdata, v, ex, pend, en;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [NEXT-1:0] ext_pin;
    logic [NSRC-1:0] periph_evt;
    cpu_in_t cpu_i;
    cpu_out_t cpu_o;
    logic [23:0] push_log;
    logic [15:0] halt_pc, last_load;
    logic [7:0] load_cnt;
    int err_count, cmp_count, seed, i, k;

    assign hready = hreadyout;

    mcu_interrupt_control dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_pin(ext_pin),
        .periph_evt(periph_evt), .cpu_i(cpu_i), .cpu_o(cpu_o), .irq(irq));

    cpu_model cpu_u (.hclk(hclk), .hresetn(hresetn), .cli(cli), .brk_cmd(brk_cmd),
        .cpu_o(cpu_o), .cpu_i(cpu_i), .push_log(push_log), .halt_pc(halt_pc),
        .last_load(last_load), .load_cnt(load_cnt));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [7:0] vrom(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    task automatic final_report;
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic timeout(input string name);
        check(name, 32'h0, 32'h1);
        final_report();
    endtask

    // single ahb-lite transfer, address phase then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        n = 0;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100)
            timeout("bus_ready");
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(name, r, exp);
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic pulse_evt(input logic [NSRC-1:0] e);
        periph_evt <= e;
        @(posedge hclk);
        periph_evt <= '0;
        @(posedge hclk);
    endtask

    // wait for one acceptance sequence and compare what the cpu saw
    task automatic accept(input logic [15:0] va, input logic br);
        logic [7:0] lc;
        logic [31:0] hc;
        int n;
        lc = load_cnt;
        hc = 32'h0;
        if (br)
            brk_cmd <= 1'b1;
        else
            cli <= 1'b1;
        @(posedge hclk);
        brk_cmd <= 1'b0;
        cli <= 1'b0;
        for (n = 0; n < 40 && load_cnt === lc; n++)
        begin
            @(negedge hclk);
            hc = hc + {31'h0, cpu_o.halt === 1'b1};
        end
        if (n >= 40)
            timeout("accept_done");
        check("halt_cycles", hc, 32'h4);
        check("pc_loaded", {16'h0, last_load}, {16'h0, vrom(va + 16'h1), vrom(va)});
        check("pushed_pc", {16'h0, push_log[23:8]}, {16'h0, halt_pc});
        check("pushed_ps", {24'h0, push_log[7:0]}, br ? 32'h34 : 32'h20);
        check("iflag_set", {31'h0, cpu_i.iflag}, 32'h1);
        check("live_brk", {31'h0, cpu_i.ps[PS_BRK_BIT]}, 32'h0);
        @(posedge hclk);
    endtask

    // ****************************************************************
    // clock and main sequence
    // ****************************************************************
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    initial
    begin
        {hresetn, hsel, hwrite, cli, brk_cmd} = '0;
        {haddr, hwdata, htrans, ext_pin, periph_evt} = '0;
        hsize = 3'h2;
        err_count = 0;
        cmp_count = 0;
        seed = 32'h17eb;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        for (i = 0; i < 40 && load_cnt !== 8'h01; i++)
            @(negedge hclk);
        if (i >= 40)
            timeout("reset_done");
        @(posedge hclk);
        check("reset_vec", {16'h0, last_load}, {16'h0, vrom(16'hfffb), vrom(VEC_RESET)});
        rd_chk("en_reset", OFS_EN, 32'h0);
        rd_chk("pol_reset", OFS_POL, 32'h0);
        rd_chk("req_reset", OFS_REQ, 32'h0);
        rd_chk("unmapped", 8'h20, 32'h0);
        for (k = 0; k < 4; k++)
        begin
            wr(OFS_REQ_CLR, 32'h007fffff);
            v = {9'h0, 23'($random(seed))};
            wr(OFS_EN, v);
            rd_chk("en_rw", OFS_EN, v);
            wr(OFS_EN, 32'h0);
            pulse_evt(v[22:0]);
            ex = v & ~{9'h0, EXT_MASK};
            rd_chk("req_latch", OFS_REQ, ex);
            wr(OFS_REQ, 32'h007fffff);
            rd_chk("req_no_set", OFS_REQ, ex);
            wr(OFS_EN, 32'h007fffff);
            @(negedge hclk);
            check("irq_level", {31'h0, irq}, {31'h0, ex != 0});
            check("iflag_gate", {31'h0, cpu_o.irq_req}, 32'h0);
            @(posedge hclk);
            wr(OFS_EN, 32'h0);
            v = {9'h0, 23'($random(seed))};
            wr(OFS_REQ_CLR, v);
            rd_chk("req_clear", OFS_REQ, ex & ~v);
            pend = ex & ~v;
            ex = {9'h0, 23'($random(seed))} & ~{9'h0, EXT_MASK};
            pulse_evt(ex[22:0]);
            rd_chk("req_more", OFS_REQ, pend | ex);
        end
        wr(OFS_REQ_CLR, 32'h007fffff);
        pend = {9'h0, 23'($random(seed))} & ~{9'h0, EXT_MASK} | 32'h1;
        pulse_evt(pend[22:0]);
        en = {9'h0, 23'($random(seed))} | 32'h1;
        wr(OFS_EN, en);
        for (k = 0; k < NSRC && (pend & en) != 0; k++)
        begin
            for (i = 0; !pend[i] || !en[i]; i++)
                ;
            accept(VEC_FIRST - 16'(2 * i), 1'b0);
            pend[i] = 1'b0;
            rd_chk("req_cleared", OFS_REQ, pend);
        end
        wr(OFS_EN, 32'h0);
        accept(VEC_BRK, 1'b1);
        rd_chk("state_brk", OFS_STATE, 32'h000000b7);
        for (k = 0; k < NEXT; k++)
        begin
            wr(OFS_REQ_CLR, 32'h007fffff);
            ext_pin[k] <= 1'b1;
            repeat (3) @(posedge hclk);
            rd_chk("edge_rise", OFS_REQ, 32'h1 << EXT_POS[k]);
            // change edge, read it back, clear, then drive the falling edge
            wr(OFS_POL, 32'h1 << k);
            rd_chk("pol_rw", OFS_POL, 32'h1 << k);
            wr(OFS_REQ_CLR, 32'h007fffff);
            ext_pin[k] <= 1'b0;
            repeat (3) @(posedge hclk);
            rd_chk("edge_fall", OFS_REQ, 32'h1 << EXT_POS[k]);
            wr(OFS_POL, 32'h0);
        end
        final_report();
    end

endmodule

`default_nettype wire
